//--- design/smsr_defines.vh
// Overview of operation
// [RULE1] Setting either receive enable starts reception
// [RULE2] Sample data pin on falling serial clock
// [RULE3] Single enable receives one word, stops
// [RULE4] Continuous enable receives until software clears it
// [RULE5] Both enables set acts as continuous
// [RULE6] Completed word moves to holding FIFO if room
// [RULE7] Transfer into FIFO sets receive-ready flag
// [RULE8] Interrupt only while receive enable bit set; code gates irq with irq_en bit 5, not the receive enables
// [RULE9] Ready flag read-only, clears when FIFO empty
// [RULE10] Holding register is two-entry FIFO
// [RULE11] Full FIFO at third word sets overrun, discards
// [RULE12] Overrun cleared only by clearing continuous enable
// [RULE13] Overrun blocks all shift-to-FIFO transfers
// [RULE14] Ninth bit buffered per entry, loads on read
// [RULE15] Software reads status before holding register
// [RULE16] Software follows documented setup order
// [RULE17] Software reads status, data, clears errors
// [RULE18] Device drives serial clock from baud generator
`ifndef SMSR_DEFINES_VH
`define SMSR_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SMSR_ADDR_IRQ_FLAGS 8'h0c
`define SMSR_ADDR_RX_STAT 8'h18
`define SMSR_ADDR_RX_DATA 8'h1a
`define SMSR_ADDR_IRQ_EN 8'h8c
`define SMSR_ADDR_TX_STAT 8'h98
`define SMSR_ADDR_BAUD 8'h99
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMSR_BIT_RX_READY 5
`define SMSR_BIT_PORT_EN 7
`define SMSR_BIT_NINE 6
`define SMSR_BIT_SINGLE 5
`define SMSR_BIT_CONT 4
`define SMSR_BIT_ADDR_DET 3
`define SMSR_BIT_OVERRUN 1
`define SMSR_BIT_NINTH 0
`define SMSR_BIT_CLK_SRC 7
`define SMSR_BIT_SYNC 4
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SMSR_RST_TX_STAT 8'h02
`define SMSR_RST_ZERO 8'h00
`endif

//--- design/smsr_receiver.v
// Local design decision: strobed register access.
`include "smsr_defines.vh"
module smsr_receiver
(
  input wire core_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire receive_data_pin_in,
  output wire receive_data_pin_out,
  output wire receive_data_pin_oe_n,
  output reg serial_clk_out,
  output wire serial_clk_oe_n,
  output wire irq
);
  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  reg [7:0] irq_en;
  reg [7:0] tx_stat;
  reg [7:0] baud_rate_divisor;
  reg serial_port_enable;
  reg nine_bit_mode;
  reg single_receive_enable;
  reg continuous_receive_enable;
  reg address_detect_enable;
  reg overrun_error_bit;
  // ----------------------------------------
  // Holding FIFO, two entries of nine bits
  // ----------------------------------------
  wire [17:0] fifo_flat;
  wire [8:0] head;
  wire [1:0] load;
  genvar gi;
  reg rd_ptr;
  reg wr_ptr;
  reg [1:0] fifo_cnt;
  // ----------------------------------------
  // Shifter and clock generation
  // ----------------------------------------
  reg [8:0] receive_shift_register;
  reg [3:0] bit_cnt;
  reg [7:0] baud_cnt;
  reg busy;
  reg din_meta;
  reg din_sync;

  wire sync_master;
  wire rx_read;
  wire fifo_full;
  wire receive_ready_flag;
  wire [3:0] word_bits;
  wire tick;
  wire fall;
  wire last_bit;
  wire push;
  wire run_enable;
  wire wr_irq_en;
  wire wr_tx_stat;
  wire wr_baud;
  wire wr_rx_stat;
  wire [8:0] word_in;
  wire pop;
  wire [1:0] next_fifo_cnt;
  reg [7:0] next_rdata;
  reg next_overrun;

  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // One compare shared by the write decodes and the data-read strobe keeps the map in step
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign wr_irq_en = reg_wr & hit(reg_addr, `SMSR_ADDR_IRQ_EN);
  assign wr_tx_stat = reg_wr & hit(reg_addr, `SMSR_ADDR_TX_STAT);
  assign wr_baud = reg_wr & hit(reg_addr, `SMSR_ADDR_BAUD);
  assign wr_rx_stat = reg_wr & hit(reg_addr, `SMSR_ADDR_RX_STAT);

  assign sync_master = serial_port_enable & tx_stat[`SMSR_BIT_SYNC]
    & tx_stat[`SMSR_BIT_CLK_SRC];
  assign rx_read = reg_rd & hit(reg_addr, `SMSR_ADDR_RX_DATA);
  assign fifo_full = fifo_cnt[1];
  assign receive_ready_flag = (fifo_cnt != 2'd0); // [RULE9]
  assign word_bits = nine_bit_mode ? 4'd9 : 4'd8;
  // Half period is the divisor plus one core cycles
  assign tick = (baud_cnt == baud_rate_divisor);
  // Clock idles low; data is taken as the driven clock falls
  assign fall = busy & tick & serial_clk_out; // [RULE2]
  assign last_bit = fall & (bit_cnt == word_bits - 4'd1);
  assign push = last_bit & ~fifo_full & ~overrun_error_bit; // [RULE6] [RULE13]
  assign run_enable = single_receive_enable | continuous_receive_enable; // [RULE1]
  assign irq = receive_ready_flag & irq_en[`SMSR_BIT_RX_READY]; // [RULE8]
  // The device only listens on the data line
  assign receive_data_pin_out = 1'b0;
  assign receive_data_pin_oe_n = 1'b1;
  assign serial_clk_oe_n = ~sync_master; // [RULE18]

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end
    else
    begin
      din_meta <= receive_data_pin_in;
      // Logic reads only the second stage; the first may be metastable
      din_sync <= din_meta;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      irq_en <= `SMSR_RST_ZERO;
    else if (wr_irq_en)
      irq_en <= reg_wdata;
  end

  // Bit 1 is a read-only status bit and keeps its reset value
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      tx_stat <= `SMSR_RST_TX_STAT;
    else if (wr_tx_stat)
      tx_stat <= {reg_wdata[7:2], tx_stat[1], reg_wdata[0]};
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      baud_rate_divisor <= `SMSR_RST_ZERO;
    else if (wr_baud)
      baud_rate_divisor <= reg_wdata;
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      serial_port_enable <= 1'b0;
      nine_bit_mode <= 1'b0;
      continuous_receive_enable <= 1'b0;
      address_detect_enable <= 1'b0;
    end
    else if (wr_rx_stat)
    begin
      serial_port_enable <= reg_wdata[`SMSR_BIT_PORT_EN];
      nine_bit_mode <= reg_wdata[`SMSR_BIT_NINE];
      continuous_receive_enable <= reg_wdata[`SMSR_BIT_CONT];
      address_detect_enable <= reg_wdata[`SMSR_BIT_ADDR_DET];
    end
  end

  // A software write beats the self-clear at the end of a word
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      single_receive_enable <= 1'b0;
    else if (wr_rx_stat)
      single_receive_enable <= reg_wdata[`SMSR_BIT_SINGLE];
    else if (last_bit && !continuous_receive_enable)
      single_receive_enable <= 1'b0; // [RULE3] [RULE5]
  end

  // ----------------------------------------
  // Overrun flag
  // ----------------------------------------
  // A late word and a cleared enable in one cycle: the set wins
  always @*
  begin
    next_overrun = overrun_error_bit;
    if (last_bit && fifo_full)
      next_overrun = 1'b1; // [RULE11]
    else if (!continuous_receive_enable)
      next_overrun = 1'b0; // [RULE12]
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      overrun_error_bit <= 1'b0;
    else
      overrun_error_bit <= next_overrun;
  end

  // ----------------------------------------
  // Serial clock generation
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      baud_cnt <= 8'h00;
      serial_clk_out <= 1'b0;
    end
    else if (!busy)
    begin
      // Each word starts from a full low phase
      baud_cnt <= 8'h00;
      serial_clk_out <= 1'b0;
    end
    else
    begin
      baud_cnt <= tick ? 8'h00 : baud_cnt + 8'h01; // [RULE18]
      if (tick)
        serial_clk_out <= ~serial_clk_out;
    end
  end

  // ----------------------------------------
  // Shift register and bit counter
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_cnt <= 4'h0;
      receive_shift_register <= 9'h000;
    end
    else if (!busy)
      bit_cnt <= 4'h0;
    else if (fall)
    begin
      receive_shift_register <= {din_sync, receive_shift_register[8:1]};
      bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  // ----------------------------------------
  // Receive control
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      busy <= ST_IDLE;
    else
    begin
      case (busy)
        ST_IDLE:
        begin
          // Overrun halts reception until the enable is cleared
          if (sync_master && run_enable && !overrun_error_bit)
            busy <= ST_SHIFT; // [RULE1]
        end
        ST_SHIFT:
        begin
          // Enables stop it only at a word boundary; losing sync master stops it mid-word, yet a half word never lands
          if (last_bit && (!continuous_receive_enable || fifo_full))
            busy <= ST_IDLE; // [RULE4] [RULE5]
          else if (!last_bit && !sync_master)
            busy <= ST_IDLE;
        end
        default:
          busy <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Holding FIFO
  // ----------------------------------------
  // The last bit is still in the synchroniser, so it joins here
  assign word_in = nine_bit_mode ?
    {din_sync, receive_shift_register[8:1]} :
    {1'b0, din_sync, receive_shift_register[8:2]};
  assign pop = rx_read & receive_ready_flag;
  assign load = {push & wr_ptr, push & ~wr_ptr};
  // Push and pop in one cycle leave the count unchanged
  assign next_fifo_cnt = fifo_cnt + {1'b0, push} - {1'b0, pop};

  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_entry
      reg [8:0] entry;
      always @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          entry <= 9'h000;
        else if (load[gi])
          entry <= word_in; // [RULE10] [RULE14]
      end
      assign fifo_flat[gi*9+8:gi*9] = entry;
    end
  endgenerate
  // Reading the head reloads the ninth-bit status with the next entry
  assign head = rd_ptr ? fifo_flat[17:9] : fifo_flat[8:0]; // [RULE14]

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fifo_cnt <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      fifo_cnt <= next_fifo_cnt; // [RULE7]
    end
  end

  // ----------------------------------------
  // Read-back words
  // ----------------------------------------
  wire [7:0] irq_flags_word;
  wire [7:0] rx_status_word;
  wire [7:0] tx_status_word;

  // Only the receive-ready flag lives in the shared flag register
  assign irq_flags_word = {2'b00, receive_ready_flag, 5'b00000}; // [RULE9]
  assign rx_status_word = {serial_port_enable, nine_bit_mode,
    single_receive_enable, continuous_receive_enable,
    address_detect_enable, 1'b0, overrun_error_bit, head[8]}; // [RULE14]
  // Bit 3 is unimplemented and reads as zero
  assign tx_status_word = {tx_stat[7:4], 1'b0, tx_stat[2:0]};

  // ----------------------------------------
  // Register reads, data one cycle later
  // ----------------------------------------
  always @*
  begin
    next_rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `SMSR_ADDR_IRQ_FLAGS:
          next_rdata = irq_flags_word;
        `SMSR_ADDR_RX_STAT:
          next_rdata = rx_status_word;
        `SMSR_ADDR_RX_DATA:
          next_rdata = head[7:0];
        `SMSR_ADDR_IRQ_EN:
          next_rdata = irq_en;
        `SMSR_ADDR_TX_STAT:
          next_rdata = tx_status_word;
        `SMSR_ADDR_BAUD:
          next_rdata = baud_rate_divisor;
        default:
          next_rdata = 8'h00;
      endcase
    end
  end

  // Read data stand for one cycle only and are zero otherwise
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end
endmodule

//--- dv/smsr_receiver_properties.sv
module smsr_receiver_properties (
  input wire core_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire receive_data_pin_out,
  input wire receive_data_pin_oe_n,
  input wire serial_clk_out,
  input wire serial_clk_oe_n,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Shadows of software writes, and a count of serial clock falls
  // ----
  reg en5, ever, single, nine;
  reg [7:0] baud;
  reg [3:0] falls;
  always @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      {en5, ever, single, nine, baud, falls} <= 16'h0000;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h8c)
        en5 <= reg_wdata[5];
      if (reg_wr && reg_addr == 8'h99)
        baud <= reg_wdata;
      if (reg_wr && reg_addr == 8'h18)
      begin
        ever <= ever | reg_wdata[5] | reg_wdata[4];
        single <= reg_wdata[5] & ~reg_wdata[4];
        nine <= reg_wdata[6];
        falls <= 4'h0;
      end
      // Counter may wrap in continuous mode; only checked in single
      else if ($fell(serial_clk_out))
        falls <= falls + 4'h1;
    end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_irq_needs_en: assert property (irq |-> en5)
    else $error("irq high while masked");
  a_flag_vs_irq: assert property
    ($past(reg_rd && reg_addr == 8'h0c && en5) |->
     reg_rdata[5] == $past(irq))
    else $error("ready flag disagrees with irq");
  a_clk_high_len: assert property
    ($rose(serial_clk_out) && baud == 8'h03 |->
     serial_clk_out [*4] ##1 !serial_clk_out)
    else $error("serial clock high phase wrong");
  a_clk_low_len: assert property
    ($fell(serial_clk_out) && baud == 8'h03 |-> !serial_clk_out [*4])
    else $error("serial clock low phase too short");
  a_clk_driven: assert property (serial_clk_out |-> !serial_clk_oe_n)
    else $error("serial clock toggles undriven");
  a_pin_released: assert property (receive_data_pin_oe_n)
    else $error("receiver drives data line");
  a_single_stops: assert property
    (single |-> falls <= (nine ? 4'h9 : 4'h8))
    else $error("single receive ran past one word");
  a_clk_needs_en: assert property (serial_clk_out |-> ever)
    else $error("serial clock without receive enable");
  a_pin_out_low: assert property (!receive_data_pin_out)
    else $error("receiver puts a level on the data line");
endmodule
bind smsr_receiver smsr_receiver_properties smsr_receiver_properties_inst (.*);

//--- dv/smsr_slave_model.sv
module smsr_slave_model (
  input wire logic core_clk,
  input wire logic serial_clk,
  input wire logic nine,
  output logic data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] q[$];
  logic [8:0] w = 9'h0aa;
  logic last = 1'b0;
  int n = 0;
  initial data = 1'b0;
  // Data moves on the rising edge so it is settled at the fall
  always @(posedge core_clk)
  begin
    last <= serial_clk;
    if (serial_clk && !last)
    begin
      if (n == 0)
        w = (q.size() > 0) ? q.pop_front() : 9'h0aa;
      data <= w[0];
      w = {~w[0], w[8:1]};
      n = (n == (nine ? 8 : 7)) ? 0 : n + 1;
    end
  end
endmodule

//--- dv/smsr_receiver_bench.sv
module smsr_receiver_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic nine = 1'b0;
  wire [7:0] reg_rdata;
  wire pin, sclk, irq;
  int n_fail = 0;
  int n_tests = 0;
  always #10 core_clk = ~core_clk;
  smsr_receiver smsr_receiver_inst (.core_clk(core_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .receive_data_pin_in(pin),
    .receive_data_pin_out(), .receive_data_pin_oe_n(),
    .serial_clk_out(sclk), .serial_clk_oe_n(), .irq(irq));
  smsr_slave_model smsr_slave_model_inst (.core_clk(core_clk),
    .serial_clk(sclk), .nine(nine), .data(pin));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("Counts: %0d compared, %0d failed", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Strobes drop off the edge, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk) #1;
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk) #1;
    chk(reg_rdata, exp);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_falls(input int n);
    int k;
    logic p;
    k = 0;
    for (int i = 0; i < 4000 && k < n; i++)
    begin
      p = sclk;
      @(posedge core_clk) #1;
      if (p === 1'b1 && sclk === 1'b0)
        k++;
    end
    if (k < n)
    begin
      n_fail++;
      complete_run();
    end
    repeat (3) @(posedge core_clk);
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(8'h98, 8'h02);
    rd(8'h55, 8'h00);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h00);
    wr(8'h99, 8'h03);
    wr(8'h98, 8'h90);
    wr(8'h18, 8'h80);
    wr(8'h8c, 8'h20);
    $display("test registers done");
    smsr_slave_model_inst.q.push_back(9'h0a5);
    wr(8'h18, 8'ha0);
    wait_falls(8);
    chk({7'h00, irq}, 8'h01);
    rd(8'h0c, 8'h20);
    rd(8'h18, 8'h80);
    rd(8'h1a, 8'ha5);
    rd(8'h0c, 8'h00);
    $display("test single done");
    for (int i = 1; i < 4; i++)
      smsr_slave_model_inst.q.push_back(9'(i * 8'h11));
    wr(8'h18, 8'hb0);
    wait_falls(24);
    rd(8'h0c, 8'h20);
    rd(8'h18, 8'hb2);
    wr(8'h8c, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(8'h8c, 8'h20);
    rd(8'h1a, 8'h11);
    rd(8'h1a, 8'h22);
    rd(8'h0c, 8'h00);
    rd(8'h18, 8'hb2);
    wr(8'h18, 8'h80);
    rd(8'h18, 8'h80);
    $display("test overrun done");
    nine <= 1'b1;
    smsr_slave_model_inst.q.push_back(9'h1c3);
    wr(8'h18, 8'he0);
    wait_falls(9);
    rd(8'h18, 8'hc1);
    rd(8'h1a, 8'hc3);
    $display("test nine bit done");
    complete_run();
  end
endmodule
